// file: src/touch_adc_serial_power_ctrl.sv
// Serial sequencer and power management of a touch screen digitizer ADC.
// Assumes shift_clock and the select come from the host; analog result arrives
// as a parallel word sampled on shift_clock; analog controls leave on clk_sys.
// What this block does
// RULE1: Mode 00: reference off, converter down between conversions, pen irq on.
// RULE2: Modes 00/10: converter down at end or select rise, up at start.
// RULE3: Mode 00 with converter down holds the Y-minus switch closed.
// RULE4: Modes 00/01 keep reference off during ratiometric conversions.
// RULE5: Mode 01: reference off, converter always on, pen irq on.
// RULE6: Mode 10: reference always on, converter down between conversions.
// RULE7: Mode 11: reference and converter always on, pen irq off.
// RULE8: Converter up on fourth falling edge after start, down on twentieth.
// RULE9: Shift clock clocks conversion and transfer; a frame is 24 clocks.
// RULE10: Select falling leaves three-state for busy and data, starts transfer.
// RULE11: Control word enters on first eight clocks, register updated per bit.
// RULE12: Once mux bits known, acquire, close switches, update reference select.
// RULE13: After three acquisition clocks, word complete, power bits applied.
// RULE14: Conversion entry holds the sample, busy high for one falling edge.
// RULE15: Switches open at conversion in single-ended, stay closed if ratiometric.
// RULE16: Twelve clocks after acquisition convert and shift result out together.
// RULE17: Host's 13th clock takes the LSB, three trailing zeros follow.
// RULE18: Host may give clocks continuously or in three bursts of eight.
// RULE19: Y drivers on for channel 001, X drivers on for channel 101.
// RULE20: Modes 00, 01, 10 turn Y-minus on at conversion end.
// RULE21: Mode 11 keeps drivers on until settings change or select rises.
// RULE22: Next control word may overlap shifting out, a conversion per 16.
// RULE23: Word MSB first; serial input ignored until a high start bit.
// RULE24: Resolution 0 gives a 12-bit conversion, 1 gives 8-bit; the bit is only stored, the result is always 12 bits.
// RULE25: Reference select 1 is single-ended, 0 is ratiometric.
// RULE26: After reset the power mode is high bit 1, low bit 0.
// RULE27: Result goes out MSB first, changing on shift clock falling edges.
`timescale 1ns/1ns
`default_nettype none
module touch_adc_serial_power_ctrl
	import touch_adc_pkg::*;
(
	input  wire logic                          clk_sys,
	input  wire logic                          reset,
	input  wire logic                          shift_clock,
	input  wire logic                          select_n,
	input  wire logic                          serial_in,
	output logic                               serial_out,
	output logic                               serial_out_oe_n,
	output logic                               busy,
	output logic                               busy_oe_n,
	input  wire logic [RESULT_BITS-1:0]        adc_result,
	input  wire logic                          pen_touched,
	output logic                               pen_touch_irq_n,
	output touch_adc_pkg::analog_ctl_t         analog_ctl,
	output touch_adc_pkg::ctrl_word_t          ctrl_word
);
	import touch_adc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Link domain: everything here runs on shift_clock; select_n is an
	// asynchronous frame reset since the host may stop the clock between frames.

	typedef enum logic [1:0] {ST_IDLE, ST_CTRL, ST_ACQ, ST_CONV} seq_t;

	seq_t                  seq_ff;
	logic [4:0]            cnt_ff;
	logic [6:0]            shreg_ff;
	ctrl_word_t            cw_ff;
	logic [RESULT_BITS-1:0] out_sr_ff;
	logic                  sout_ff;
	logic                  busy_ff;
	logic                  conv_tgl_ff;
	logic                  start_tgl_ff;
	logic                  end_tgl_ff;
	logic [RESULT_BITS-1:0] res_cap_ff;

	// Frame reset follows select; clock stops between frames, so reset async.
	wire frame_rst = select_n;

	// Rising edge: sample serial_in [RULE11] [RULE23]
	always_ff @(posedge shift_clock or posedge frame_rst) begin
		if (frame_rst) begin
			seq_ff   <= ST_IDLE;
			cnt_ff   <= 5'h00;
			shreg_ff <= 7'h00;
		end else begin
			unique case (seq_ff)
				ST_IDLE: begin
					if (serial_in) begin // [RULE23]
						seq_ff <= ST_CTRL;
						cnt_ff <= 5'h01;
					end
				end
				ST_CTRL: begin
					shreg_ff <= {shreg_ff[5:0], serial_in}; // [RULE11]
					cnt_ff   <= cnt_ff + 5'h01;
					if (cnt_ff == 5'(CTRL_BITS - 1))
						seq_ff <= ST_CONV; // [RULE13]
				end
				ST_ACQ: seq_ff <= ST_CONV;
				ST_CONV: begin
					cnt_ff <= cnt_ff + 5'h01;
					// Overlap: a new start bit late in the frame begins the next word [RULE22]
					if (cnt_ff >= 5'(OVERLAP_CLOCKS - 1) && serial_in) begin
						seq_ff <= ST_CTRL;
						cnt_ff <= 5'h01;
					end else if (cnt_ff == 5'(FRAME_CLOCKS - 1)) begin // [RULE9]
						seq_ff <= ST_IDLE;
						cnt_ff <= 5'h00;
					end
				end
			endcase
		end
	end

	// Control fields become visible as soon as their bits are in [RULE11] [RULE12]
	wire in_ctrl    = (seq_ff == ST_CTRL);
	wire word_done  = in_ctrl && (cnt_ff == 5'(CTRL_BITS - 1));
	wire conv_entry = (seq_ff == ST_CONV) && (cnt_ff == 5'(CTRL_BITS));

	// Falling edge: control register, power bits, busy and data out
	always_ff @(negedge shift_clock or posedge frame_rst) begin
		if (frame_rst) begin
			busy_ff <= 1'b0;
			sout_ff <= 1'b0;
		end else begin
			busy_ff <= 1'b0;
			if (in_ctrl && cnt_ff == 5'h04)
				cw_ff.channel_select <= shreg_ff[2:0]; // [RULE12]
			if (in_ctrl && cnt_ff == 5'h05)
				cw_ff.resolution <= shreg_ff[0]; // [RULE24]
			if (in_ctrl && cnt_ff == 5'h06)
				cw_ff.ref_mode_select <= shreg_ff[0]; // [RULE12] [RULE25]
			if (conv_entry) begin
				cw_ff.power_mode_hi <= shreg_ff[1]; // [RULE13]
				cw_ff.power_mode_lo <= shreg_ff[0];
				busy_ff   <= 1'b1; // [RULE14]
				out_sr_ff <= res_cap_ff;
			end
			if (seq_ff == ST_CONV && cnt_ff > 5'(CTRL_BITS)) begin
				sout_ff   <= out_sr_ff[RESULT_BITS-1]; // [RULE16] [RULE27]
				out_sr_ff <= {out_sr_ff[RESULT_BITS-2:0], 1'b0}; // [RULE17]
			end
		end
	end

	// Event toggles must survive frame aborts, so only the system reset clears
	// them; both ends of each crossing then agree after reset.
	always_ff @(negedge shift_clock or posedge reset) begin
		if (reset) begin
			conv_tgl_ff  <= 1'b0;
			start_tgl_ff <= 1'b0;
			end_tgl_ff   <= 1'b0;
		end else begin
			if (conv_entry)
				conv_tgl_ff <= ~conv_tgl_ff; // [RULE13]
			if (in_ctrl && cnt_ff == 5'(PWRUP_FALL))
				start_tgl_ff <= ~start_tgl_ff; // [RULE8]
			if (seq_ff == ST_CONV && cnt_ff == 5'(PWRDN_FALL))
				end_tgl_ff <= ~end_tgl_ff; // [RULE8] [RULE20]
		end
	end

	// High impedance while select is high [RULE10]
	assign serial_out      = sout_ff;
	assign serial_out_oe_n = select_n;
	assign busy            = busy_ff;
	assign busy_oe_n       = select_n;

	////////////////////////////////////////////////////////////////////////////
	// System domain: analog controls

	logic [2:0] sel_sync_ff;
	logic [2:0] conv_sync_ff;
	logic [2:0] start_sync_ff;
	logic [2:0] end_sync_ff;
	logic [1:0] pen_sync_ff;
	logic       converting_ff;
	logic       adc_up_ff;
	logic       ymin_ff;
	logic       drv_keep_ff;
	logic       th_ff;
	ctrl_word_t cw_sys_ff;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sel_sync_ff   <= 3'h7;
			conv_sync_ff  <= 3'h0;
			start_sync_ff <= 3'h0;
			end_sync_ff   <= 3'h0;
			pen_sync_ff   <= 2'h0;
		end else begin
			sel_sync_ff   <= {sel_sync_ff[1:0], select_n};
			conv_sync_ff  <= {conv_sync_ff[1:0], conv_tgl_ff};
			start_sync_ff <= {start_sync_ff[1:0], start_tgl_ff};
			end_sync_ff   <= {end_sync_ff[1:0], end_tgl_ff};
			pen_sync_ff   <= {pen_sync_ff[0], pen_touched};
		end
	end

	wire sel_rise   = sel_sync_ff[1] & ~sel_sync_ff[2];
	wire conv_ev    = conv_sync_ff[1] ^ conv_sync_ff[2];
	wire start_ev   = start_sync_ff[1] ^ start_sync_ff[2];
	wire end_ev     = end_sync_ff[1] ^ end_sync_ff[2];
	wire [1:0] pm   = {cw_sys_ff.power_mode_hi, cw_sys_ff.power_mode_lo};
	wire ratio      = ~cw_sys_ff.ref_mode_select;
	wire pen_en     = (pm != PM_ON); // [RULE1] [RULE5] [RULE6] [RULE7]

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cw_sys_ff     <= '{3'h0, 1'b0, 1'b0, PM_RST[1], PM_RST[0]}; // [RULE26]
			converting_ff <= 1'b0;
			adc_up_ff     <= 1'b0;
			ymin_ff       <= 1'b0;
			drv_keep_ff   <= 1'b0;
			th_ff         <= 1'b0;
		end else begin
			if (start_ev) begin
				adc_up_ff     <= 1'b1; // [RULE2] [RULE8]
				converting_ff <= 1'b1;
				ymin_ff       <= 1'b0;
				drv_keep_ff   <= 1'b1;
				th_ff         <= 1'b0;
			end
			if (conv_ev) begin
				cw_sys_ff <= cw_ff; // Word stable for a whole conversion here
				th_ff     <= 1'b1; // [RULE14]
				if (cw_ff.ref_mode_select)
					drv_keep_ff <= 1'b0; // [RULE15]
			end
			if (end_ev || sel_rise) begin
				converting_ff <= 1'b0;
				adc_up_ff     <= 1'b0; // [RULE2] [RULE8]
				if (pm != PM_ON) begin
					ymin_ff     <= 1'b1; // [RULE3] [RULE20]
					drv_keep_ff <= 1'b0;
				end else if (sel_rise)
					drv_keep_ff <= 1'b0; // [RULE21]
			end
		end
	end

	// Converter power [RULE1] [RULE5] [RULE6] [RULE7]
	assign analog_ctl.adc_on     = pm[0] | adc_up_ff;
	// Reference only with PD1 set; never in ratiometric with PD1 clear [RULE4]
	assign analog_ctl.ref_on     = pm[1];
	assign analog_ctl.y_drv_on   = drv_keep_ff && cw_sys_ff.channel_select == CH_XPOS; // [RULE19]
	assign analog_ctl.x_drv_on   = drv_keep_ff && cw_sys_ff.channel_select == CH_YPOS; // [RULE19]
	assign analog_ctl.y_minus_on = ymin_ff; // [RULE3]
	assign analog_ctl.pen_irq_en = pen_en && !converting_ff;
	assign analog_ctl.track_hold = th_ff;
	assign pen_touch_irq_n       = ~(analog_ctl.pen_irq_en & pen_sync_ff[1]);
	assign ctrl_word             = cw_sys_ff;

	// Result is sampled in the link domain on every shift_clock rising edge; the
	// analog front end holds adc_result steady across the frame.
	always_ff @(posedge shift_clock)
		res_cap_ff <= adc_result;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_busy_pulse;
		@(negedge shift_clock) disable iff (select_n)
		busy_ff |=> !busy_ff;
	endproperty
	a_busy_pulse: assert property (p_busy_pulse) else $error("busy longer than one clock"); // [RULE14]

	property p_oe_sel;
		@(posedge clk_sys) disable iff (reset)
		busy_oe_n == select_n;
	endproperty
	a_oe_sel: assert property (p_oe_sel) else $error("busy enable not tied to select"); // [RULE10]

	property p_pen_off11;
		@(posedge clk_sys) disable iff (reset)
		(pm == PM_ON) |-> pen_touch_irq_n;
	endproperty
	a_pen_off11: assert property (p_pen_off11) else $error("pen irq in always-on mode"); // [RULE7]

	property p_ref_hi;
		@(posedge clk_sys) disable iff (reset)
		analog_ctl.ref_on == pm[1];
	endproperty
	a_ref_hi: assert property (p_ref_hi) else $error("reference power wrong"); // [RULE4]

	property p_adc_on01;
		@(posedge clk_sys) disable iff (reset)
		(pm[0]) |-> analog_ctl.adc_on;
	endproperty
	a_adc_on01: assert property (p_adc_on01) else $error("converter off in on mode"); // [RULE5]

	property p_ymin_down;
		@(posedge clk_sys) disable iff (reset)
		(pm == PM_AUTO && $fell(adc_up_ff)) |-> analog_ctl.y_minus_on;
	endproperty
	a_ymin_down: assert property (p_ymin_down) else $error("Y-minus open in power-down"); // [RULE3]

	property p_end_down;
		@(posedge clk_sys) disable iff (reset)
		end_ev |=> !adc_up_ff;
	endproperty
	a_end_down: assert property (p_end_down) else $error("converter stays up after end"); // [RULE8]

	property p_start_up;
		@(posedge clk_sys) disable iff (reset)
		(start_ev && !end_ev && !sel_rise) |=> adc_up_ff;
	endproperty
	a_start_up: assert property (p_start_up) else $error("converter not up at start"); // [RULE2]

	property p_busy_entry;
		@(negedge shift_clock) disable iff (select_n)
		conv_entry |=> busy_ff;
	endproperty
	a_busy_entry: assert property (p_busy_entry) else $error("busy not raised at conversion"); // [RULE14]

	property p_start_tgl;
		@(negedge shift_clock) disable iff (select_n)
		(in_ctrl && cnt_ff == 5'(PWRUP_FALL)) |=> (start_tgl_ff != $past(start_tgl_ff));
	endproperty
	a_start_tgl: assert property (p_start_tgl) else $error("no power-up event on fourth fall"); // [RULE8]

	property p_end_tgl;
		@(negedge shift_clock) disable iff (select_n)
		(seq_ff == ST_CONV && cnt_ff == 5'(PWRDN_FALL)) |=> (end_tgl_ff != $past(end_tgl_ff));
	endproperty
	a_end_tgl: assert property (p_end_tgl) else $error("no power-down event on last fall"); // [RULE8]

	property p_trail_zero;
		@(negedge shift_clock) disable iff (select_n)
		(seq_ff == ST_CONV && cnt_ff > 5'(CTRL_BITS + RESULT_BITS)) |=> !sout_ff;
	endproperty
	a_trail_zero: assert property (p_trail_zero) else $error("trailing bit not zero"); // [RULE17]

	property p_ref_on10;
		@(posedge clk_sys) disable iff (reset)
		(pm == PM_REF) |-> analog_ctl.ref_on;
	endproperty
	a_ref_on10: assert property (p_ref_on10) else $error("reference off in mode 10"); // [RULE6]

	property p_ratio_keep;
		@(posedge clk_sys) disable iff (reset)
		(conv_ev && !cw_ff.ref_mode_select && !start_ev && !end_ev && !sel_rise) |=> $stable(drv_keep_ff);
	endproperty
	a_ratio_keep: assert property (p_ratio_keep) else $error("drivers dropped in ratiometric"); // [RULE15]

	property p_sel_down;
		@(posedge clk_sys) disable iff (reset)
		sel_rise |=> !adc_up_ff;
	endproperty
	a_sel_down: assert property (p_sel_down) else $error("converter up after select rise"); // [RULE2]

	property p_irq_on;
		@(posedge clk_sys) disable iff (reset)
		(pm != PM_ON && !converting_ff && pen_sync_ff[1]) |-> !pen_touch_irq_n;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("pen irq missing when enabled"); // [RULE5]

	property p_drv_release11;
		@(posedge clk_sys) disable iff (reset)
		(sel_rise && pm == PM_ON) |=> !drv_keep_ff;
	endproperty
	a_drv_release11: assert property (p_drv_release11) else $error("drivers kept after select"); // [RULE21]

	property p_conv_hold;
		@(posedge clk_sys) disable iff (reset)
		conv_ev |=> analog_ctl.track_hold;
	endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("track-and-hold not in hold"); // [RULE14]
endmodule
`default_nettype wire

// file: src/touch_adc_pkg.sv
// Constants and types shared by the touch ADC serial sequencer.
// Assumes one system clock domain plus the serial shift clock domain.
package touch_adc_pkg;
	localparam int CTRL_BITS       = 8;
	localparam int RESULT_BITS     = 12;
	localparam int ACQ_CLOCKS      = 3;
	localparam int CONV_CLOCKS     = 12;
	localparam int TRAIL_ZEROS     = 3;
	localparam int FRAME_CLOCKS    = 24;
	localparam int OVERLAP_CLOCKS  = 16;
	localparam int PWRUP_FALL      = 4;
	localparam int PWRDN_FALL      = 20;
	localparam logic [2:0] CH_XPOS = 3'h1;
	localparam logic [2:0] CH_YPOS = 3'h5;
	localparam logic [1:0] PM_RST  = 2'h2;
	localparam logic [1:0] PM_AUTO = 2'h0;
	localparam logic [1:0] PM_ADC  = 2'h1;
	localparam logic [1:0] PM_REF  = 2'h2;
	localparam logic [1:0] PM_ON   = 2'h3;
	localparam logic [4:0] BIT_CNT_W_MAX = 5'h1F;

	typedef struct packed {
		logic [2:0] channel_select;
		logic       resolution;
		logic       ref_mode_select;
		logic       power_mode_hi;
		logic       power_mode_lo;
	} ctrl_word_t;

	typedef struct packed {
		logic ref_on;
		logic adc_on;
		logic y_drv_on;
		logic x_drv_on;
		logic y_minus_on;
		logic pen_irq_en;
		logic track_hold;
	} analog_ctl_t;
endpackage

// file: bench/touch_host.sv
// Host model that drives the serial port of the touch ADC sequencer.
// Assumes the bench calls frame() only while select_n is idle high.
`timescale 1ns/1ns
`default_nettype none
module touch_host (
	output logic      shift_clock,
	output logic      select_n,
	output logic      serial_in,
	input  wire logic serial_out,
	input  wire logic busy
);
	initial begin
		shift_clock = 1'b0;
		select_n    = 1'b1;
		serial_in   = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// Shift clock stands low outside frames and between bursts
	task automatic frame(input logic [7:0] word, input int lead, input int len,
		input logic burst, output logic [23:0] dout, output logic [23:0] bsy);
		int rel;
		#30;
		select_n = 1'b0;
		#24;
		for (int k = 0; k < lead + len; k++) begin
			rel = k - lead;
			serial_in = (rel >= 0 && rel < 8) ? word[7 - rel] : 1'b0;
			#24 shift_clock = 1'b1;
			if (rel >= 0) begin
				dout[23 - rel] = serial_out;
				bsy[23 - rel]  = busy;
			end
			#24 shift_clock = 1'b0;
			if (burst && rel % 8 == 7) #200;
		end
		#24 select_n = 1'b1;
		// Deselected line must not keep the last value
		serial_in = ~serial_in;
	endtask
endmodule
`default_nettype wire

// file: bench/touch_adc_serial_power_ctrl_test.sv
// Self-checking bench of the touch ADC serial sequencer.
// Assumes touch_host drives the serial port on its own 48 ns clock.
`timescale 1ns/1ns
`default_nettype none
module touch_adc_serial_power_ctrl_test;
	import touch_adc_pkg::*;
	logic                   clk_sys = 1'b0;
	logic                   reset   = 1'b1;
	logic                   shift_clock;
	logic                   select_n;
	logic                   serial_in;
	logic                   serial_out;
	logic                   serial_out_oe_n;
	logic                   busy;
	logic                   busy_oe_n;
	logic [RESULT_BITS-1:0] adc_result;
	logic                   pen_touched;
	logic                   pen_touch_irq_n;
	analog_ctl_t            analog_ctl;
	ctrl_word_t             ctrl_word;
	int                     failures  = 0;
	int                     tests_run = 0;
	logic [23:0]            dout;
	logic [23:0]            bsy;
	logic [7:0]             word;
	logic [1:0]             mode;
	logic [2:0]             ch;
	logic [RESULT_BITS-1:0] res;
	always #5 clk_sys = ~clk_sys;
	touch_host host_u (.shift_clock(shift_clock), .select_n(select_n),
		.serial_in(serial_in), .serial_out(serial_out), .busy(busy));
	touch_adc_serial_power_ctrl dut_u (.clk_sys(clk_sys), .reset(reset),
		.shift_clock(shift_clock), .select_n(select_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .busy(busy),
		.busy_oe_n(busy_oe_n), .adc_result(adc_result), .pen_touched(pen_touched),
		.pen_touch_irq_n(pen_touch_irq_n), .analog_ctl(analog_ctl), .ctrl_word(ctrl_word));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic sys_wait(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		adc_result  = '0;
		pen_touched = 1'b0;
		void'($urandom(32'h03FB));
		sys_wait(10);
		reset = 1'b0;
		sys_wait(2);
		chk("mode_bits", 16'h2, {ctrl_word.power_mode_hi, ctrl_word.power_mode_lo});
		chk("ref_on_rst", 16'h1, analog_ctl.ref_on);
		for (int i = 0; i < 16; i++) begin
			mode = i[1:0];
			ch = (i % 3 == 0) ? CH_XPOS : (i % 3 == 1) ? CH_YPOS : 3'($urandom);
			word = {1'b1, ch, 1'($urandom), 1'($urandom), mode};
			res = RESULT_BITS'($urandom);
			adc_result  = res;
			pen_touched = 1'($urandom);
			// Aborted frame first: select rising must reset the link
			if (i == 5) host_u.frame(word, 2, 5, 1'b0, dout, bsy);
			fork
				host_u.frame(word, i % 4, 24, i[2], dout, bsy);
				begin
					repeat (i % 4 + 16) @(posedge shift_clock);
					chk("oe_n", 16'h0, {serial_out_oe_n, busy_oe_n});
					chk("adc_on_mid", 16'h1, analog_ctl.adc_on);
					if ((ch == CH_XPOS || ch == CH_YPOS) && !word[2])
						chk("drivers", {ch == CH_XPOS, ch == CH_YPOS},
							{analog_ctl.y_drv_on, analog_ctl.x_drv_on});
					if (!word[2] && !word[1])
						chk("ref_ratio", 16'h0, analog_ctl.ref_on);
				end
			join
			sys_wait(10);
			chk("result", {res, 3'h0}, dout[14:0]);
			chk("busy", 16'h2, bsy[15:14]);
			chk("ctrl_word", word[6:0], ctrl_word);
			chk("oe_idle", 16'h3, {serial_out_oe_n, busy_oe_n});
			chk("track_hold", 16'h1, analog_ctl.track_hold);
			chk("power", mode, {analog_ctl.ref_on, analog_ctl.adc_on});
			if (mode != PM_ON) chk("y_minus", 16'h1, analog_ctl.y_minus_on);
			pen_touched = 1'b1;
			sys_wait(6);
			chk("pen_irq_n", mode == PM_ON, pen_touch_irq_n);
			$display("test %0d done", i);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
